// ### common/adc_regs_pkg.sv
`default_nettype none
package adc_regs_pkg;

  // full register addresses; only the area nibble and the low nine bits decode
  localparam logic [27:0] RES_A_HIGH_ADDR = 28'h5fffee0;
  localparam logic [27:0] RES_A_LOW_ADDR  = 28'h5fffee1;
  localparam logic [27:0] RES_B_HIGH_ADDR = 28'h5fffee2;
  localparam logic [27:0] RES_B_LOW_ADDR  = 28'h5fffee3;
  localparam logic [27:0] RES_C_HIGH_ADDR = 28'h5fffee4;
  localparam logic [27:0] RES_C_LOW_ADDR  = 28'h5fffee5;
  localparam logic [27:0] RES_D_HIGH_ADDR = 28'h5fffee6;
  localparam logic [27:0] RES_D_LOW_ADDR  = 28'h5fffee7;
  localparam logic [27:0] CTRL_STAT_ADDR  = 28'h5fffee8;
  localparam logic [27:0] TRIG_CTRL_ADDR  = 28'h5fffee9;

  // widths and reset values
  localparam int unsigned ADDR_W       = 28;
  localparam int unsigned RESULT_W     = 10;
  localparam int unsigned RESULT_REGS  = 4;
  localparam logic [9:0]  RESULT_RST   = 10'h000;
  localparam logic [7:0]  TEMP_RST     = 8'h00;
  localparam logic [7:0]  CTRL_STAT_RST = 8'h00;
  localparam logic [7:0]  TRIG_CTRL_RST = 8'h7f;
  localparam logic [6:0]  TRIG_RSVD_ONES = 7'h7f;
  localparam logic [7:0]  UNMAPPED_READ = 8'h00;
  localparam logic [5:0]  LOW_BYTE_PAD  = 6'h00;

  // conversion_control_status bit positions
  localparam int unsigned CS_DONE_FLAG_BIT = 7;
  localparam int unsigned CS_IRQ_EN_BIT    = 6;
  localparam int unsigned CS_START_BIT     = 5;
  localparam int unsigned CS_SCAN_BIT      = 4;
  localparam int unsigned CS_CLK_SEL_BIT   = 3;
  localparam int unsigned CS_GROUP_BIT     = 2;
  // trigger_control bit position
  localparam int unsigned TC_EXT_EN_BIT    = 7;

  typedef enum logic [2:0] {
    SEL_NONE   = 3'b000,
    SEL_RES_HI = 3'b001,
    SEL_RES_LO = 3'b010,
    SEL_CSR    = 3'b011,
    SEL_TRIG   = 3'b100
  } regSel_t;

  typedef enum logic [0:0] {
    SEQ_IDLE = 1'b0,
    SEQ_WAIT = 1'b1
  } seqState_t;

  // address bits 23..9 take no part in the decode
  function automatic regSel_t decodeSel(input logic [27:0] addr);
    regSel_t sel;
    sel = SEL_NONE;
    if (addr[27:24] != RES_A_HIGH_ADDR[27:24]) begin
      sel = SEL_NONE;
    end else if (addr[8:0] == CTRL_STAT_ADDR[8:0]) begin
      sel = SEL_CSR;
    end else if (addr[8:0] == TRIG_CTRL_ADDR[8:0]) begin
      sel = SEL_TRIG;
    end else if (addr[8:3] == RES_A_HIGH_ADDR[8:3]) begin
      sel = addr[0] ? SEL_RES_LO : SEL_RES_HI;
    end
    return sel;
  endfunction

  // result register index from a byte address
  function automatic logic [1:0] resultIndex(input logic [27:0] addr);
    return addr[2:1];
  endfunction

endpackage
`default_nettype wire

// ### rtl/trigger_sync.sv
`default_nettype none
module trigger_sync (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic rstN,
  input  wire logic ce,
  // pin and event
  input  wire logic pinN,
  output logic      fallPulse
);

  logic meta_r;
  logic sync_r;
  logic prev_r;

  // meta_r feeds only sync_r
  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      meta_r <= 1'h1;
      sync_r <= 1'h1;
      prev_r <= 1'h1;
    end else if (ce) begin
      meta_r <= pinN;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign fallPulse = ce & prev_r & ~sync_r;

  fallEdge_a: assert property (@(posedge clk_sys) disable iff (!rstN)
    fallPulse |-> !sync_r && $past(sync_r))
    else $error("trigger pulse without a falling edge");

endmodule
`default_nettype wire

// ### rtl/result_bank.sv
`default_nettype none
module result_bank
  import adc_regs_pkg::*;
(
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rstN,
  input  wire logic       ce,
  input  wire logic       clear,
  // converter side
  input  wire logic       wrEn,
  input  wire logic [1:0] wrIdx,
  input  wire logic [9:0] wrValue,
  // cpu side
  input  wire logic [1:0] rdIdx,
  input  wire logic       rdUpper,
  output logic [7:0]      upperByte,
  output logic [7:0]      tempByte
);

  logic [9:0] result_r [RESULT_REGS];
  logic [7:0] temp_r;

  // only the converter writes here; no cpu path exists
  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      for (int i = 0; i < RESULT_REGS; i++) begin
        result_r[i] <= RESULT_RST;
      end
    end else if (ce) begin
      if (clear) begin
        for (int i = 0; i < RESULT_REGS; i++) begin
          result_r[i] <= RESULT_RST;
        end
      end else if (wrEn) begin
        result_r[wrIdx] <= wrValue;
      end
    end
  end

  // the low byte is snapshotted so a high-then-low read pair stays coherent
  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      temp_r <= TEMP_RST;
    end else if (ce) begin
      if (clear) begin
        temp_r <= TEMP_RST;
      end else if (rdUpper) begin
        temp_r <= {result_r[rdIdx][1:0], LOW_BYTE_PAD};
      end
    end
  end

  assign upperByte = result_r[rdIdx][9:2];
  assign tempByte  = temp_r;

  lowPad_a: assert property (@(posedge clk_sys) disable iff (!rstN)
    tempByte[5:0] == LOW_BYTE_PAD)
    else $error("low byte reserved bits not zero");

  tempLatch_a: assert property (@(posedge clk_sys) disable iff (!rstN)
    ce && rdUpper && !clear |=> tempByte[7:6] == $past(result_r[rdIdx][1:0]))
    else $error("temp latch missed lower bits");

  resultStore_a: assert property (@(posedge clk_sys) disable iff (!rstN)
    ce && wrEn && !clear |=> result_r[$past(wrIdx)] == $past(wrValue))
    else $error("result not stored in its register");

  clearAll_a: assert property (@(posedge clk_sys) disable iff (!rstN)
    ce && clear |=> result_r[0] == RESULT_RST && result_r[3] == RESULT_RST && temp_r == TEMP_RST)
    else $error("standby did not clear results");

endmodule
`default_nettype wire

// ### rtl/adc_result_register_interface.sv
`default_nettype none
// How it works
// - each conversion yields a ten-bit result held in a result register
// - four sixteen-bit result registers, readable only by software
// - result bits nine to two sit in the upper byte
// - result bit one at low-byte bit 7, bit zero at bit 6
// - low-byte bits five to zero always read zero
// - inputs 0/4,1/5,2/6,3/7 land in registers a,b,c,d
// - inputs 0..3 form group 0, inputs 4..7 form group 1
// - reset and standby clear every result register to zero
// - results readable any time; high byte direct, low byte via latch
// - completion flag clears by writing zero, by dma acknowledge, or by reset or standby; writing one does nothing
// - decode uses address bits 27..24 and 8..0 only
// - single mode converts one selected input per start
// - scan mode cycles over one to four inputs of a group repeatedly
// - completion interrupt may be raised at every conversion cycle end
// - completion request can start the dma controller
// - conversion starts by software or by the external trigger
// - single mode clears the start bit when conversion finishes
// - scan mode sets completion flag only after all selected inputs
// - trigger enable set: falling trigger edge starts conversion
// - high-byte read latches low byte; later low-byte read returns latch
module adc_result_register_interface
  import adc_regs_pkg::*;
(
  // clock, reset, enable
  input  wire logic              clk_sys,
  input  wire logic              resetn,
  input  wire logic              ce,
  input  wire logic              standby,
  // cpu peripheral bus, byte wide
  input  wire logic [ADDR_W-1:0] busAddr,
  input  wire logic              busRead,
  input  wire logic              busWrite,
  input  wire logic [7:0]        busWdata,
  output logic [7:0]             busRdata,
  // external start trigger pin
  input  wire logic              extStartTriggerN,
  // analog converter core
  output logic                   convStart,
  output logic [2:0]             convChannel,
  output logic                   convFast,
  input  wire logic              convDone,
  input  wire logic [9:0]        convResult,
  // interrupt and dma
  output logic                   conversionDoneIrq,
  output logic                   dmaStartReq,
  input  wire logic              dmaAck
);

  logic [1:0] rstPipe_r;
  logic       rstN;

  // release the asynchronous reset through two flops
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rstPipe_r <= 2'h0;
    end else begin
      rstPipe_r <= {rstPipe_r[0], 1'h1};
    end
  end
  assign rstN = rstPipe_r[1];

  regSel_t    sel;
  logic [1:0] rdIdx;
  logic       csrWrite;
  logic       trigWrite;
  logic       rdUpper;
  logic [7:0] upperByte;
  logic [7:0] tempByte;
  logic       trigFall;

  logic [7:0] csr_r;
  logic       extEn_r;
  logic [7:0] busRdata_r;
  logic       convStart_r;
  logic [2:0] convChannel_r;
  logic       irq_r;
  logic       dmaReq_r;
  seqState_t  seqState_r;

  logic       doneFlag;
  logic       startBit;
  logic       scanMode;
  logic [2:0] chanSel;
  logic [2:0] groupBase;
  logic       doneEvt;
  logic       cycleEnd;

  assign sel       = decodeSel(busAddr);
  assign rdIdx     = resultIndex(busAddr);
  // result selects are absent here, so cpu writes never reach them
  assign csrWrite  = ce & busWrite & (sel == SEL_CSR);
  assign trigWrite = ce & busWrite & (sel == SEL_TRIG);
  assign rdUpper   = ce & busRead & (sel == SEL_RES_HI) & ~standby;

  assign doneFlag  = csr_r[CS_DONE_FLAG_BIT];
  assign startBit  = csr_r[CS_START_BIT];
  assign scanMode  = csr_r[CS_SCAN_BIT];
  assign chanSel   = csr_r[2:0];
  // channel bit 2 picks the group; scan runs from the group's first input
  assign groupBase = {csr_r[CS_GROUP_BIT], 2'h0};

  assign doneEvt  = ce & (seqState_r == SEQ_WAIT) & startBit & convDone;
  // in scan mode a cycle ends only on the last selected input
  assign cycleEnd = doneEvt & (~scanMode | (convChannel_r == chanSel));

  trigger_sync u_trig (
    .clk_sys   (clk_sys),
    .rstN      (rstN),
    .ce        (ce),
    .pinN      (extStartTriggerN),
    .fallPulse (trigFall)
  );

  result_bank u_bank (
    .clk_sys   (clk_sys),
    .rstN      (rstN),
    .ce        (ce),
    .clear     (standby),
    .wrEn      (doneEvt),
    .wrIdx     (convChannel_r[1:0]),
    .wrValue   (convResult),
    .rdIdx     (rdIdx),
    .rdUpper   (rdUpper),
    .upperByte (upperByte),
    .tempByte  (tempByte)
  );

  // control and status register
  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      csr_r <= CTRL_STAT_RST;
    end else if (ce) begin
      if (standby) begin
        csr_r <= CTRL_STAT_RST;
      end else begin
        if (csrWrite) begin
          csr_r[6:0] <= busWdata[6:0];
          if (!busWdata[CS_DONE_FLAG_BIT]) begin
            csr_r[CS_DONE_FLAG_BIT] <= 1'h0;
          end
        end
        if (dmaAck) begin
          csr_r[CS_DONE_FLAG_BIT] <= 1'h0;
        end
        // a software write in the same cycle keeps its own start value
        if (doneEvt && !scanMode && !csrWrite) begin
          csr_r[CS_START_BIT] <= 1'h0;
        end
        if (trigFall && extEn_r) begin
          csr_r[CS_START_BIT] <= 1'h1;
        end
        // set wins over a zero write or dma acknowledge arriving together
        if (cycleEnd) begin
          csr_r[CS_DONE_FLAG_BIT] <= 1'h1;
        end
      end
    end
  end

  // trigger control: only the enable bit is stored
  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      extEn_r <= TRIG_CTRL_RST[TC_EXT_EN_BIT];
    end else if (ce) begin
      if (standby) begin
        extEn_r <= TRIG_CTRL_RST[TC_EXT_EN_BIT];
      end else if (trigWrite) begin
        extEn_r <= busWdata[TC_EXT_EN_BIT];
      end
    end
  end

  // conversion sequencer
  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      seqState_r    <= SEQ_IDLE;
      convStart_r   <= 1'h0;
      convChannel_r <= 3'h0;
    end else if (ce) begin
      convStart_r <= 1'h0;
      if (standby) begin
        seqState_r <= SEQ_IDLE;
      end else begin
        case (seqState_r)
          SEQ_IDLE: begin
            if (startBit) begin
              convChannel_r <= scanMode ? groupBase : chanSel;
              convStart_r   <= 1'h1;
              seqState_r    <= SEQ_WAIT;
            end
          end
          SEQ_WAIT: begin
            if (doneEvt) begin
              if (!scanMode) begin
                seqState_r <= SEQ_IDLE;
              end else if (convChannel_r == chanSel) begin
                convChannel_r <= groupBase;
                convStart_r   <= 1'h1;
              end else begin
                convChannel_r <= convChannel_r + 3'h1;
                convStart_r   <= 1'h1;
              end
            end else if (!startBit) begin
              // software halt; a late done from the core is dropped
              seqState_r <= SEQ_IDLE;
            end
          end
          default: begin
            seqState_r <= SEQ_IDLE;
          end
        endcase
      end
    end
  end

  // read data
  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      busRdata_r <= UNMAPPED_READ;
    end else if (ce && busRead) begin
      if (sel == SEL_RES_HI) begin
        busRdata_r <= upperByte;
      end else if (sel == SEL_RES_LO) begin
        busRdata_r <= tempByte;
      end else if (sel == SEL_CSR) begin
        busRdata_r <= csr_r;
      end else if (sel == SEL_TRIG) begin
        busRdata_r <= {extEn_r, TRIG_RSVD_ONES};
      end else begin
        busRdata_r <= UNMAPPED_READ;
      end
    end
  end

  // interrupt and dma request follow the flag while enabled
  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      irq_r    <= 1'h0;
      dmaReq_r <= 1'h0;
    end else if (ce) begin
      irq_r    <= doneFlag & csr_r[CS_IRQ_EN_BIT];
      dmaReq_r <= doneFlag & csr_r[CS_IRQ_EN_BIT];
    end
  end

  assign busRdata          = busRdata_r;
  assign convStart         = convStart_r;
  assign convChannel       = convChannel_r;
  assign convFast          = csr_r[CS_CLK_SEL_BIT];
  assign conversionDoneIrq = irq_r;
  assign dmaStartReq       = dmaReq_r;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstN);

  flagZeroClr_a: assert property (
    csrWrite && !standby && !busWdata[7] && !cycleEnd |=> !doneFlag)
    else $error("zero write did not clear flag");

  flagOneKeep_a: assert property (
    csrWrite && !standby && busWdata[7] && !doneFlag && !cycleEnd |=> !doneFlag)
    else $error("one write set the flag");

  singleStop_a: assert property (
    doneEvt && !scanMode && !standby && !csrWrite && !(trigFall && extEn_r)
    |=> !startBit && doneFlag && seqState_r == SEQ_IDLE)
    else $error("single conversion did not stop");

  scanMidFlag_a: assert property (
    doneEvt && scanMode && convChannel_r != chanSel && !doneFlag && !standby |=> !doneFlag)
    else $error("flag set before scan cycle end");

  scanWrap_a: assert property (
    doneEvt && scanMode && convChannel_r == chanSel && !standby
    |=> convStart && convChannel == $past(groupBase))
    else $error("scan did not wrap to group start");

  singleStart_a: assert property (
    ce && seqState_r == SEQ_IDLE && startBit && !standby && !scanMode
    |=> convStart && convChannel == $past(chanSel) ##1 !convStart)
    else $error("single start did not request its input");

  trigStart_a: assert property (
    trigFall && extEn_r && !standby |=> startBit)
    else $error("trigger edge did not start");

  swStart_a: assert property (
    csrWrite && busWdata[5] && seqState_r == SEQ_IDLE && !standby && ce
    ##1 ce[*2] |-> convStart)
    else $error("software start did not reach the core");

  irqFollow_a: assert property (
    ce && doneFlag && csr_r[6] |=> conversionDoneIrq && dmaStartReq)
    else $error("interrupt not raised with flag");

  csrDecode_a: assert property (
    ce && busRead && busAddr[27:24] == CTRL_STAT_ADDR[27:24]
    && busAddr[8:0] == CTRL_STAT_ADDR[8:0] |=> busRdata == $past(csr_r))
    else $error("status read ignored partial decode");

  standbyClr_a: assert property (
    ce && standby |=> csr_r == CTRL_STAT_RST && !extEn_r && seqState_r == SEQ_IDLE)
    else $error("standby did not clear control");

  singleDone_c: cover property (doneEvt && !scanMode);
  scanWrapped_c: cover property (doneEvt && scanMode && convChannel_r == chanSel);
  trigStarted_c: cover property (trigFall && extEn_r && seqState_r == SEQ_IDLE);
  pairRead_c: cover property (rdUpper ##1 ce && busRead && sel == SEL_RES_LO);

endmodule
`default_nettype wire

// ### tb/conv_core_model.sv
`default_nettype none
module conv_core_model (
  // clock
  input  wire logic       clk_sys,
  // start from the block
  input  wire logic       convStart,
  input  wire logic [2:0] convChannel,
  // bench controls
  input  wire logic       slow,
  input  wire logic [9:0] resTable [8],
  // answer
  output logic            convDone,
  output logic [9:0]      convResult
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  initial convDone = 1'b0;
  initial convResult = 10'h000;
  // result bus toggles while idle so a stale sample never matches by luck
  always @(posedge clk_sys) begin
    convDone <= 1'b0;
    if (convStart === 1'b1) begin
      cnt <= slow ? 20 : 2;
      convResult <= ~convResult;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
      convResult <= ~convResult;
    end else if (cnt == 1) begin
      cnt <= 0;
      convDone <= 1'b1;
      convResult <= resTable[convChannel];
    end else begin
      convResult <= ~convResult;
    end
  end
endmodule
`default_nettype wire

// ### tb/tb_adc_result_register_interface.sv
`default_nettype none
module tb_adc_result_register_interface
  import adc_regs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys = 1'b0;
  logic        resetn = 1'b0;
  logic        standby = 1'b0;
  logic        ce = 1'b1;
  logic [27:0] busAddr = 28'h0000000;
  logic        busRead = 1'b0;
  logic        busWrite = 1'b0;
  logic [7:0]  busWdata = 8'h00;
  logic [7:0]  busRdata;
  logic        extStartTriggerN = 1'b1;
  logic        convStart, convFast, convDone, conversionDoneIrq, dmaStartReq;
  logic [2:0]  convChannel;
  logic [9:0]  convResult;
  logic        dmaAck = 1'b0;
  logic        slow = 1'b0;
  logic [9:0]  resTable [8] = '{default: 10'h000};
  logic [31:0] rs = 32'h00000021;
  logic [7:0]  d;
  int          n_fail = 0, comparisons = 0, cycles = 0, nDone = 0;

  adc_result_register_interface dut (.clk_sys(clk_sys), .resetn(resetn), .ce(ce),
    .standby(standby), .busAddr(busAddr), .busRead(busRead), .busWrite(busWrite),
    .busWdata(busWdata), .busRdata(busRdata), .extStartTriggerN(extStartTriggerN),
    .convStart(convStart), .convChannel(convChannel), .convFast(convFast),
    .convDone(convDone), .convResult(convResult), .conversionDoneIrq(conversionDoneIrq),
    .dmaStartReq(dmaStartReq), .dmaAck(dmaAck));
  conv_core_model core (.clk_sys(clk_sys), .convStart(convStart), .convChannel(convChannel),
    .slow(slow), .resTable(resTable), .convDone(convDone), .convResult(convResult));

  initial begin
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (convDone === 1'b1) nDone <= nDone + 1;
    if (cycles == 40000) begin
      n_fail = n_fail + 1;
      stop_test();
    end
  end

  task automatic stop_test();
    if (n_fail == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    comparisons = comparisons + 1;
    if (g !== e) begin
      n_fail = n_fail + 1;
      $display("Error t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk1(input logic g, input logic e);
    comparisons = comparisons + 1;
    if (g !== e) begin
      n_fail = n_fail + 1;
      $display("Error t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic nextRnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
  endtask
  // bits 23..9 filled with noise
  function automatic logic [27:0] mix(input logic [27:0] a);
    return {a[27:24], rs[14:0], a[8:0]};
  endfunction
  function automatic logic [7:0] expHi(input logic [9:0] v);
    return v[9:2];
  endfunction
  function automatic logic [7:0] expLo(input logic [9:0] v);
    return {v[1:0], 6'h00};
  endfunction
  task automatic rd(input logic [27:0] a, output logic [7:0] v);
    @(posedge clk_sys);
    busAddr <= a;
    busRead <= 1'b1;
    @(posedge clk_sys);
    busRead <= 1'b0;
    @(posedge clk_sys);
    #1 v = busRdata;
  endtask
  task automatic wr(input logic [27:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    busAddr <= a;
    busWdata <= v;
    busWrite <= 1'b1;
    @(posedge clk_sys);
    busWrite <= 1'b0;
  endtask
  task automatic waitIrq();
    int i;
    for (i = 0; i < 400; i++) begin
      @(posedge clk_sys);
      #1;
      if (conversionDoneIrq === 1'b1) break;
    end
    chk1(conversionDoneIrq, 1'b1);
  endtask
  task automatic pinLow();
    @(posedge clk_sys);
    extStartTriggerN <= 1'b0;
    repeat (4) @(posedge clk_sys);
    extStartTriggerN <= 1'b1;
  endtask
  task automatic checkRes(input logic [2:0] ch, input logic [9:0] v);
    logic [27:0] hi;
    hi = RES_A_HIGH_ADDR + {ch[1:0], 1'b0};
    nextRnd();
    rd(mix(hi), d);
    chk8(d, expHi(v));
    rd(mix(hi + 28'h0000001), d);
    chk8(d, expLo(v));
  endtask

  initial begin
    logic [7:0] cs;
    int         n0;
    repeat (20) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (4) @(posedge clk_sys);
    // low byte before any high read gives the cleared latch
    rd(RES_B_LOW_ADDR, d);
    chk8(d, TEMP_RST);
    for (int a = 0; a < 8; a++) begin
      wr(RES_A_HIGH_ADDR + a, 8'hff);
      rd(RES_A_HIGH_ADDR + a, d);
      chk8(d, 8'h00);
    end
    rd(CTRL_STAT_ADDR, d);
    chk8(d, CTRL_STAT_RST);
    rd(TRIG_CTRL_ADDR, d);
    chk8(d, TRIG_CTRL_RST);
    rd(28'h5fffeea, d);
    chk8(d, UNMAPPED_READ);
    rd(28'h4fffee0, d);
    chk8(d, UNMAPPED_READ);
    // single conversions on every input, alternate slow core
    for (int c = 0; c < 8; c++) begin
      nextRnd();
      resTable[c] <= (c == 0) ? 10'h3ff : (c == 1) ? 10'h001 : rs[9:0];
      slow <= c[0];
      cs = 8'h60 | {4'h0, c[0], c[2:0]};
      wr(CTRL_STAT_ADDR, cs);
      waitIrq();
      chk1(convFast, c[0]);
      rd(CTRL_STAT_ADDR, d);
      chk8(d, cs ^ 8'ha0);
      checkRes(c[2:0], resTable[c]);
      wr(CTRL_STAT_ADDR, cs ^ 8'ha0);
      rd(CTRL_STAT_ADDR, d);
      chk8(d, cs ^ 8'ha0);
      wr(CTRL_STAT_ADDR, cs ^ 8'h20);
      rd(CTRL_STAT_ADDR, d);
      chk8(d, cs ^ 8'h20);
      chk1(conversionDoneIrq, 1'b0);
    end
    // scan over inputs 4..6, flag only after the third result
    slow <= 1'b1;
    @(posedge clk_sys);
    n0 = nDone;
    wr(CTRL_STAT_ADDR, 8'h76);
    waitIrq();
    chk8(8'(nDone - n0), 8'h03);
    wr(CTRL_STAT_ADDR, 8'h00);
    repeat (30) @(posedge clk_sys);
    for (int c = 4; c < 7; c++) checkRes(c[2:0], resTable[c]);
    // trigger disabled: pin edge starts nothing
    wr(CTRL_STAT_ADDR, 8'h47);
    pinLow();
    repeat (10) @(posedge clk_sys);
    rd(CTRL_STAT_ADDR, d);
    chk8(d, 8'h47);
    wr(TRIG_CTRL_ADDR, 8'h80);
    rd(TRIG_CTRL_ADDR, d);
    chk8(d, 8'hff);
    nextRnd();
    resTable[7] <= rs[9:0];
    pinLow();
    waitIrq();
    chk1(dmaStartReq, 1'b1);
    checkRes(3'h7, resTable[7]);
    @(posedge clk_sys);
    dmaAck <= 1'b1;
    @(posedge clk_sys);
    dmaAck <= 1'b0;
    repeat (3) @(posedge clk_sys);
    #1 chk1(dmaStartReq, 1'b0);
    // with the clock enable low a standby pulse must leave result register d alone
    @(posedge clk_sys);
    ce <= 1'b0;
    standby <= 1'b1;
    @(posedge clk_sys);
    ce <= 1'b1;
    standby <= 1'b0;
    checkRes(3'h7, resTable[7]);
    // standby clears results and both control registers
    @(posedge clk_sys);
    standby <= 1'b1;
    @(posedge clk_sys);
    standby <= 1'b0;
    checkRes(3'h7, 10'h000);
    rd(CTRL_STAT_ADDR, d);
    chk8(d, CTRL_STAT_RST);
    rd(TRIG_CTRL_ADDR, d);
    chk8(d, TRIG_CTRL_RST);
    stop_test();
  end
endmodule
`default_nettype wire
